// >>> hdl/dac_dem_dither_offset_ctrl.v
// Element-matching, dither and offset control for converter channels A and B.
// Assumes a byte register port, one clock, inputs synchronous to sys_clk,
// and a sample stream carrying one sample per channel per transfer.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dac_dem_dither_offset_regs.vh"

module dac_dem_dither_offset_ctrl #(
	parameter SAMPLE_W = 16,
	parameter FIFO_DEPTH = 4,
	parameter FIFO_PTR_W = 2
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire [11:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output wire [7:0] reg_rdata,
	input wire datapath_enable,
	input wire offset_change_block,
	input wire in_valid,
	output wire in_ready,
	input wire [SAMPLE_W-1:0] in_sample_a,
	input wire [SAMPLE_W-1:0] in_sample_b,
	output wire out_valid,
	input wire out_ready,
	output wire [SAMPLE_W-1:0] out_sample_a,
	output wire [SAMPLE_W-1:0] out_sample_b,
	output wire [1:0] match_mode_a,
	output wire [1:0] match_mode_b,
	output wire [1:0] match_adjust_a,
	output wire [1:0] match_adjust_b,
	output wire match_adjust_on_a,
	output wire match_adjust_on_b,
	output wire [1:0] noise_mode_a,
	output wire [1:0] noise_mode_b
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Limit an offset to the range allowed by the noise setting
	function [`OFS_W-1:0] clamp_ofs;
		input [`OFS_W-1:0] ofs;
		input [1:0] noise;
		reg [`OFS_W-1:0] lim;
		reg [`OFS_W-1:0] neg_lim;
		begin
			if (noise == `NOISE_OFF)
				lim = `OFS_LIM_PLAIN;
			else
				lim = `OFS_LIM_DITHER;
			neg_lim = ~lim + 1'b1;
			if ($signed(ofs) > $signed(lim))
				clamp_ofs = lim;
			else if ($signed(ofs) < $signed(neg_lim))
				clamp_ofs = neg_lim;
			else
				clamp_ofs = ofs;
		end
	endfunction

	// Add a sign-extended offset to a sample with saturation
	function [SAMPLE_W-1:0] add_sat;
		input [SAMPLE_W-1:0] smp;
		input [`OFS_W-1:0] ofs;
		reg [SAMPLE_W:0] sum;
		begin
			sum = {smp[SAMPLE_W-1], smp} + {{(SAMPLE_W+1-`OFS_W){ofs[`OFS_W-1]}}, ofs};
			if (sum[SAMPLE_W] != sum[SAMPLE_W-1])
				add_sat = {sum[SAMPLE_W], {(SAMPLE_W-1){~sum[SAMPLE_W]}}};
			else
				add_sat = sum[SAMPLE_W-1:0];
		end
	endfunction

	// Adjust value passed on only in single-edge data-independent mode
	function [2:0] eff_adjust;
		input [3:0] adj;
		input [1:0] mode;
		begin
			if (mode == `MATCH_SE_INDEP && adj <= `ADJ_MAX_VALID)
				eff_adjust = {1'b1, adj[1:0]};
			else
				eff_adjust = 3'h0;
		end
	endfunction

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// One select per byte address, used by the read path and, all but sel_status, by the write path
	wire sel_adjust;
	wire sel_dither;
	wire sel_ofs0_lo;
	wire sel_ofs0_hi;
	wire sel_ofs1_lo;
	wire sel_ofs1_hi;
	wire sel_status;

	assign sel_adjust = (reg_addr == `ADDR_MATCH_ADJUST);
	assign sel_dither = (reg_addr == `ADDR_MATCH_DITHER);
	assign sel_ofs0_lo = (reg_addr == `ADDR_OFS0_LO);
	assign sel_ofs0_hi = (reg_addr == `ADDR_OFS0_HI);
	assign sel_ofs1_lo = (reg_addr == `ADDR_OFS1_LO);
	assign sel_ofs1_hi = (reg_addr == `ADDR_OFS1_HI);
	assign sel_status = (reg_addr == `ADDR_STATUS);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// Programmed registers
	reg [7:0] adjust_reg;
	reg [7:0] dither_reg;
	reg [15:0] ofs0_reg;
	reg [15:0] ofs1_reg;

	// Offsets as seen by the datapath
	reg [`OFS_W-1:0] live_ofs0_reg;
	reg [`OFS_W-1:0] live_ofs1_reg;

	// Read path
	reg [7:0] rdata_reg;
	reg [7:0] rdata_next;
	wire [7:0] status_byte;

	// Control outputs and datapath
	reg [2:0] eff_a_reg;
	reg [2:0] eff_b_reg;
	wire [FIFO_PTR_W:0] fifo_level;
	wire [`OFS_W-1:0] clamped_a;
	wire [`OFS_W-1:0] clamped_b;
	wire clamp_hit_a;
	wire clamp_hit_b;

	always @(posedge sys_clk) begin
		if (sys_rst)
			adjust_reg <= `RST_MATCH_ADJUST;
		else if (reg_write && sel_adjust)
			adjust_reg <= reg_wdata;
	end

	always @(posedge sys_clk) begin
		if (sys_rst)
			dither_reg <= `RST_MATCH_DITHER;
		else if (reg_write && sel_dither)
			dither_reg <= reg_wdata;
	end

	// Channel 0 low byte first, channel 1 two bytes above
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			ofs0_reg <= `RST_OFS;
		end else if (reg_write) begin
			if (sel_ofs0_lo)
				ofs0_reg[7:0] <= reg_wdata;
			if (sel_ofs0_hi)
				ofs0_reg[15:8] <= reg_wdata;
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			ofs1_reg <= `RST_OFS;
		end else if (reg_write) begin
			if (sel_ofs1_lo)
				ofs1_reg[7:0] <= reg_wdata;
			if (sel_ofs1_hi)
				ofs1_reg[15:8] <= reg_wdata;
		end
	end

	// Programmed offsets reach the datapath only while changes are not blocked,
	// so a two-byte update lands in one step when the block is lifted
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			live_ofs0_reg <= {`OFS_W{1'b0}};
			live_ofs1_reg <= {`OFS_W{1'b0}};
		end else if (!offset_change_block) begin
			live_ofs0_reg <= ofs0_reg[`OFS_VAL_HI:0];
			live_ofs1_reg <= ofs1_reg[`OFS_VAL_HI:0];
		end
	end

	// Status: datapath state, block state, clamp activity and FIFO fill
	assign status_byte = {datapath_enable, offset_change_block, clamp_hit_b, clamp_hit_a,
		{(4-FIFO_PTR_W-1){1'b0}}, fifo_level};

	// Read data stand in the cycle after the strobe only
	always @* begin
		rdata_next = 8'h00;
		if (reg_read) begin
			if (sel_adjust)
				rdata_next = adjust_reg;
			if (sel_dither)
				rdata_next = dither_reg;
			if (sel_ofs0_lo)
				rdata_next = ofs0_reg[7:0];
			if (sel_ofs0_hi)
				rdata_next = ofs0_reg[15:8];
			if (sel_ofs1_lo)
				rdata_next = ofs1_reg[7:0];
			if (sel_ofs1_hi)
				rdata_next = ofs1_reg[15:8];
			if (sel_status)
				rdata_next = status_byte;
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	assign reg_rdata = rdata_reg;

	// ----------------------------------------------------------------
	// Converter control outputs
	// ----------------------------------------------------------------
	// Effective adjust, zero unless the channel is single-edge independent
	always @(posedge sys_clk) begin
		if (sys_rst)
			eff_a_reg <= 3'h0;
		else
			eff_a_reg <= eff_adjust(adjust_reg[`ADJ_CH0_HI:`ADJ_CH0_LO],
				dither_reg[`MODE_A_HI:`MODE_A_LO]);
	end

	always @(posedge sys_clk) begin
		if (sys_rst)
			eff_b_reg <= 3'h0;
		else
			eff_b_reg <= eff_adjust(adjust_reg[`ADJ_CH1_HI:`ADJ_CH1_LO],
				dither_reg[`MODE_B_HI:`MODE_B_LO]);
	end

	assign match_mode_b = dither_reg[`MODE_B_HI:`MODE_B_LO];
	assign match_mode_a = dither_reg[`MODE_A_HI:`MODE_A_LO];
	assign noise_mode_b = dither_reg[`NOISE_B_HI:`NOISE_B_LO];
	assign noise_mode_a = dither_reg[`NOISE_A_HI:`NOISE_A_LO];
	assign match_adjust_a = eff_a_reg[1:0];
	assign match_adjust_b = eff_b_reg[1:0];
	assign match_adjust_on_a = eff_a_reg[2];
	assign match_adjust_on_b = eff_b_reg[2];

	// ----------------------------------------------------------------
	// Offset datapath
	// ----------------------------------------------------------------
	// Limit picked from the live noise field at each sample
	assign clamped_a = clamp_ofs(live_ofs0_reg, noise_mode_a);
	assign clamped_b = clamp_ofs(live_ofs1_reg, noise_mode_b);
	assign clamp_hit_a = (clamped_a != live_ofs0_reg);
	assign clamp_hit_b = (clamped_b != live_ofs1_reg);

	wire [2*SAMPLE_W-1:0] fifo_in_data;
	wire [2*SAMPLE_W-1:0] fifo_out_data;
	wire [SAMPLE_W-1:0] sum_a;
	wire [SAMPLE_W-1:0] sum_b;

	// Each channel saturates on its own before the pair is queued
	assign sum_a = add_sat(in_sample_a, clamped_a);
	assign sum_b = add_sat(in_sample_b, clamped_b);
	assign fifo_in_data = {sum_b, sum_a};
	assign out_sample_a = fifo_out_data[SAMPLE_W-1:0];
	assign out_sample_b = fifo_out_data[2*SAMPLE_W-1:SAMPLE_W];

	sample_fifo #(
		.WIDTH(2*SAMPLE_W),
		.DEPTH(FIFO_DEPTH),
		.PTR_W(FIFO_PTR_W)
	) u_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(fifo_in_data),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

endmodule // dac_dem_dither_offset_ctrl

`default_nettype wire

// >>> hdl/dac_dem_dither_offset_regs.vh
// Register map, field positions, reset values and limits of the
// element-matching, dither and offset control block.
// Assumes a byte-wide register port with a 12-bit byte address.
`ifndef DAC_DEM_DITHER_OFFSET_REGS_VH
`define DAC_DEM_DITHER_OFFSET_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_MATCH_ADJUST 12'h0727
`define ADDR_MATCH_DITHER 12'h0729
`define ADDR_OFS0_LO 12'h072a
`define ADDR_OFS0_HI 12'h072b
`define ADDR_OFS1_LO 12'h072c
`define ADDR_OFS1_HI 12'h072d
`define ADDR_STATUS 12'h072e

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_MATCH_ADJUST 8'h11
`define RST_MATCH_DITHER 8'h00
`define RST_OFS 16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADJ_CH1_HI 7
`define ADJ_CH1_LO 4
`define ADJ_CH0_HI 3
`define ADJ_CH0_LO 0
`define MODE_B_HI 7
`define MODE_B_LO 6
`define MODE_A_HI 5
`define MODE_A_LO 4
`define NOISE_B_HI 3
`define NOISE_B_LO 2
`define NOISE_A_HI 1
`define NOISE_A_LO 0
`define OFS_VAL_HI 12
`define OFS_W 13

// ----------------------------------------------------------------
// Encodings and limits
// ----------------------------------------------------------------
`define MATCH_SE_INDEP 2'h0
`define MATCH_DE_INDEP 2'h1
`define MATCH_DATA_DEP 2'h2
`define MATCH_OFF 2'h3
`define NOISE_SE 2'h0
`define NOISE_DE 2'h1
`define NOISE_OFF 2'h3
`define ADJ_MAX_VALID 4'h3
`define OFS_LIM_DITHER 13'h0080
`define OFS_LIM_PLAIN 13'h0f80

`endif

// >>> hdl/sample_fifo.v
// Small synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 4,
	parameter PTR_W = 2
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [PTR_W:0] level
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr_reg;
	reg [PTR_W-1:0] rd_ptr_reg;
	reg [PTR_W:0] count_reg;
	wire push;
	wire pop;

	assign in_ready = (count_reg != DEPTH[PTR_W:0]);
	assign out_valid = (count_reg != {(PTR_W+1){1'b0}});
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg];
	assign level = count_reg;

	function [PTR_W-1:0] ptr_inc;
		input [PTR_W-1:0] p;
		begin
			if (p == DEPTH[PTR_W-1:0] - 1'b1)
				ptr_inc = {PTR_W{1'b0}};
			else
				ptr_inc = p + 1'b1;
		end
	endfunction

	always @(posedge sys_clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			wr_ptr_reg <= {PTR_W{1'b0}};
			rd_ptr_reg <= {PTR_W{1'b0}};
			count_reg <= {(PTR_W+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule // sample_fifo

`default_nettype wire

// >>> verif/dac_dem_dither_offset_ctrl_sva.sv
// Checker for the offset control block, watching its top-level ports only.
// Assumes the register header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "dac_dem_dither_offset_regs.vh"

module dac_dem_dither_offset_ctrl_chk #(
	parameter SAMPLE_W = 16
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [SAMPLE_W-1:0] out_sample_a,
	input wire logic [1:0] match_mode_a,
	input wire logic [1:0] match_mode_b,
	input wire logic [1:0] match_adjust_a,
	input wire logic match_adjust_on_a,
	input wire logic match_adjust_on_b,
	input wire logic [1:0] noise_mode_a,
	input wire logic [1:0] noise_mode_b
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	fields_reset_a: assert property ($past(sys_rst) |->
		{match_mode_b, match_mode_a, noise_mode_b, noise_mode_a} == 8'h00) else $error("mode reset");
	dither_read_a: assert property ($past(reg_read && reg_addr == `ADDR_MATCH_DITHER) |->
		reg_rdata == {match_mode_b, match_mode_a, noise_mode_b, noise_mode_a}) else $error("rd");
	adj_gate_a_a: assert property (match_adjust_on_a |->
		$past(match_mode_a) == 2'h0 || $past(match_mode_a, 2) == 2'h0) else $error("adj a");
	adj_gate_b_a: assert property (match_adjust_on_b |->
		$past(match_mode_b) == 2'h0 || $past(match_mode_b, 2) == 2'h0) else $error("adj b");
	adj_zero_a: assert property (!match_adjust_on_a |-> match_adjust_a == 2'h0)
		else $error("adjust not zero");
	full_nonempty_a: assert property (!in_ready |-> out_valid)
		else $error("full but empty");
	out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample_a))
		else $error("output not held");
	push_show_a: assert property (in_valid && in_ready |=> out_valid)
		else $error("push not shown");
	cover property (in_valid && !in_ready);
	cover property (match_adjust_on_a ##1 !match_adjust_on_a);
	cover property (noise_mode_a == 2'h2 && in_valid && in_ready);
endmodule // dac_dem_dither_offset_ctrl_chk

bind dac_dem_dither_offset_ctrl dac_dem_dither_offset_ctrl_chk #(.SAMPLE_W(SAMPLE_W)) chk_i (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
	.out_ready(out_ready), .out_sample_a(out_sample_a), .match_mode_a(match_mode_a),
	.match_mode_b(match_mode_b), .match_adjust_a(match_adjust_a),
	.match_adjust_on_a(match_adjust_on_a), .match_adjust_on_b(match_adjust_on_b),
	.noise_mode_a(noise_mode_a), .noise_mode_b(noise_mode_b)
);
`default_nettype wire

// >>> verif/tb_dac_dem_dither_offset_ctrl.sv
// Self-checking bench for the offset control block.
// Assumes the design files and the register header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dac_dem_dither_offset_regs.vh"

module tb_dac_dem_dither_offset_ctrl;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] reg_addr = 12'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0, reg_read = 1'b0, in_valid = 1'b0, out_ready = 1'b0;
	logic datapath_enable = 1'b0;
	logic offset_change_block = 1'b0;
	logic [15:0] in_sample_a = 16'h0000, in_sample_b = 16'h0000;
	wire [7:0] reg_rdata;
	wire [15:0] out_sample_a, out_sample_b;
	wire [1:0] match_mode_a, match_mode_b, match_adjust_a, match_adjust_b;
	wire [1:0] noise_mode_a, noise_mode_b;
	wire in_ready, out_valid, match_adjust_on_a, match_adjust_on_b;
	int n_checks = 0;
	int bad_count = 0;
	int i;
	// ------------------------------------------------
	// Rows: noise mode A, offset, sample, expected A and B
	// ------------------------------------------------
	logic [1:0] r_nz [8] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h0};
	logic [12:0] r_of [8] = '{13'h0064, 13'h00c8, 13'h1f38, 13'h012c, 13'h0fff, 13'h1000,
		13'h1ffb, 13'h0f80};
	logic [15:0] r_sm [8] = '{16'h03e8, 16'h0000, 16'h0000, 16'h0010, 16'h0000, 16'h0000,
		16'h8002, 16'h7d00};
	logic [15:0] r_ea [8] = '{16'h044c, 16'h0080, 16'hff80, 16'h0090, 16'h0f80, 16'hf080,
		16'h8000, 16'h7d80};
	logic [15:0] r_eb [8] = '{16'h044c, 16'h00c8, 16'hff38, 16'h013c, 16'h0f80, 16'hf080,
		16'h8000, 16'h7fff};

	dac_dem_dither_offset_ctrl dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.datapath_enable(datapath_enable), .offset_change_block(offset_change_block),
		.in_valid(in_valid), .in_ready(in_ready), .in_sample_a(in_sample_a),
		.in_sample_b(in_sample_b), .out_valid(out_valid), .out_ready(out_ready),
		.out_sample_a(out_sample_a), .out_sample_b(out_sample_b),
		.match_mode_a(match_mode_a), .match_mode_b(match_mode_b),
		.match_adjust_a(match_adjust_a), .match_adjust_b(match_adjust_b),
		.match_adjust_on_a(match_adjust_on_a), .match_adjust_on_b(match_adjust_on_b),
		.noise_mode_a(noise_mode_a), .noise_mode_b(noise_mode_b)
	);

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e, input string what);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, e, what);
	endtask

	task automatic wofs(input logic [11:0] a, input logic [12:0] v);
		wr(a, v[7:0]);
		wr(a + 12'h0001, {3'h0, v[12:8]});
	endtask

	task automatic push(input logic [15:0] a, input logic [15:0] b);
		@(posedge sys_clk);
		in_sample_a <= a;
		in_sample_b <= b;
		in_valid <= 1'b1;
		@(posedge sys_clk);
		in_valid <= 1'b0;
	endtask

	task automatic pop(input logic [15:0] ea, input logic [15:0] eb);
		int w = 0;
		#1;
		while (out_valid !== 1'b1 && w < 20) begin
			@(posedge sys_clk);
			#1;
			w++;
		end
		chk(out_valid, 1'b1, "out_valid wait");
		chk(out_sample_a, ea, "out_sample_a");
		chk(out_sample_b, eb, "out_sample_b");
		@(posedge sys_clk);
		out_ready <= 1'b1;
		@(posedge sys_clk);
		out_ready <= 1'b0;
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		report_and_stop();
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(`ADDR_MATCH_ADJUST, 8'h11, "adjust reset");
		rd(`ADDR_MATCH_DITHER, 8'h00, "dither reset");
		rd(`ADDR_OFS1_HI, 8'h00, "offset reset");
		chk(match_adjust_a, 2'h1, "adjust a");
		$display("reset test done");
		wr(`ADDR_MATCH_ADJUST, 8'h32);
		rd(`ADDR_MATCH_ADJUST, 8'h32, "adjust store");
		wr(12'h0728, 8'hff);
		rd(12'h0728, 8'h00, "unmapped");
		for (i = 0; i < 4; i++) begin
			wr(`ADDR_MATCH_DITHER, {i[1:0], i[1:0], 4'hf});
			repeat (2) @(posedge sys_clk);
			#1 chk(match_mode_a, i[1:0], "mode a");
			chk(match_mode_b, i[1:0], "mode b");
			chk(match_adjust_a, (i == 0) ? 2'h2 : 2'h0, "adjust a");
			chk(match_adjust_on_b, (i == 0), "adjust b on");
			chk(match_adjust_on_a, (i == 0), "adjust a on");
			chk(match_adjust_b, (i == 0) ? 2'h3 : 2'h0, "adjust b");
		end
		$display("mode test done");
		for (i = 0; i < 8; i++) begin
			wr(`ADDR_MATCH_DITHER, {4'h0, 2'h3, r_nz[i]});
			wofs(`ADDR_OFS0_LO, r_of[i]);
			wofs(`ADDR_OFS1_LO, r_of[i]);
			chk(noise_mode_a, r_nz[i], "noise a");
			chk(noise_mode_b, 2'h3, "noise b");
			push(r_sm[i], r_sm[i]);
			pop(r_ea[i], r_eb[i]);
		end
		$display("row test done");
		wr(`ADDR_MATCH_DITHER, 8'h0f);
		push(16'h0000, 16'h0000);
		pop(16'h0f80, 16'h0f80);
		offset_change_block <= 1'b1;
		wofs(`ADDR_OFS0_LO, 13'h0032);
		rd(`ADDR_STATUS, 8'h40, "status blocked");
		push(16'h0000, 16'h0000);
		pop(16'h0f80, 16'h0f80);
		offset_change_block <= 1'b0;
		push(16'h0000, 16'h0000);
		pop(16'h0032, 16'h0f80);
		$display("block test done");
		datapath_enable <= 1'b1;
		for (i = 0; i < 4; i++) begin
			push(i[15:0], i[15:0]);
		end
		#1 chk(in_ready, 1'b0, "in_ready full");
		rd(`ADDR_STATUS, 8'h84, "status full");
		for (i = 0; i < 4; i++) begin
			pop(16'h0032 + i[15:0], 16'h0f80 + i[15:0]);
		end
		#1 chk(out_valid, 1'b0, "out_valid empty");
		$display("fifo test done");
		report_and_stop();
	end
endmodule // tb_dac_dem_dither_offset_ctrl
`default_nettype wire
